/* File: iot_cfg.svh */
// register offsets, field positions, reset values and timing constants
// assumes a 32-bit register port with byte addresses on word boundaries
`ifndef IOT_CFG_SVH
`define IOT_CFG_SVH

// register byte offsets
`define IOT_REG_CTRL  8'h00
`define IOT_REG_TDLY  8'h04
`define IOT_REG_RDLY  8'h08
`define IOT_REG_RDUR  8'h0c
`define IOT_REG_INV   8'h10
`define IOT_REG_OEN   8'h14
`define IOT_REG_IFEN  8'h18
`define IOT_REG_LSEL  8'h1c
`define IOT_REG_PORTS 8'h20
`define IOT_REG_STAT  8'h24
`define IOT_REG_OUTS  8'h28

// control register fields
`define IOT_CTRL_RUN  0
`define IOT_CTRL_ENC  1
`define IOT_CTRL_ALL  2
`define IOT_CTRL_SIG  3
`define IOT_CTRL_NPN  5
`define IOT_CTRL_JOB  6

// interface enable fields
`define IOT_IF_IO     0
`define IOT_IF_SER    1
`define IOT_IF_NET    2
`define IOT_IF_FB     3

// reset values
`define IOT_NET_CMD   16'h07d6
`define IOT_NET_DAT   16'h07d5
`define IOT_IFEN_RST  4'hf

// timing
`define IOT_CLK_NS    4
`define IOT_TICK_MS   1
`define IOT_NS_PER_MS 1000000

`endif

/* File: iot_pkg.sv */
// types shared by the output timing block
// assumes iot_cfg.svh for numeric constants
package iot_pkg;

	typedef enum logic [1:0] {
		IOT_IDLE = 2'b00,
		IOT_TDLY = 2'b01,
		IOT_EVAL = 2'b10
	} iot_state_type;

	typedef enum logic [1:0] {
		IOT_SIG_RESULT = 2'b00,
		IOT_SIG_TRIG   = 2'b01,
		IOT_SIG_DUR    = 2'b10,
		IOT_SIG_RSVD   = 2'b11
	} iot_sig_type;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} iot_bus_type;

endpackage : iot_pkg

/* File: iot_timing.sv */
// trigger, result delay and output signalling for an inspection sensor
// assumes one 250 MHz clock, an evaluation engine on the same clock,
// and trigger and encoder pins that are asynchronous to it
//
// What this block does
// - wait trigger delay before starting evaluation
// - encoder mode counts steps instead of ms
// - result delay on all outputs or ejector
// - result delay measured from the trigger
// - result duration holds output level
// - job change or config mode drops pending
// - config mode returns outputs to default
// - invert flips default and result level
// - change on result holds until next
// - change on trigger clears outputs inactive, output 0 only in all-delay mode
// - valid duration returns output inactive
// - ready high only when trigger acceptable
// - valid high only with valid results
// - NPN inverts every output level
// - separate enable per output and interface
// - logic-only outputs over data interfaces
// - logic output picks detector or expression
// - network ports default 2006 and 2005
// - trigger drops ready and valid
// - all-delay: ready at end, valid later
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "iot_cfg.svh"

module iot_timing #(
	parameter int NOUT      = 5,
	parameter int NLOG      = 4,
	parameter int DEPTH     = 4,
	parameter int MS_CYCLES = `IOT_TICK_MS * `IOT_NS_PER_MS / `IOT_CLK_NS
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	// register port
	input  wire iot_pkg::iot_bus_type bus,
	output logic [31:0]            rdata,
	// pins from the field
	input  wire logic              trig_pin,
	input  wire logic              enc_pin,
	// evaluation engine
	output logic                   eval_start,
	input  wire logic              eval_done,
	input  wire logic [NOUT-1:0]   eval_res,
	input  wire logic [NLOG-1:0]   det_res,
	input  wire logic [NLOG-1:0]   expr_res,
	// output pins
	output logic [NOUT-1:0]        out_pin,
	output logic                   ready_pin,
	output logic                   valid_pin,
	// data interfaces
	output logic [NLOG-1:0]        ser_logic,
	output logic [NLOG-1:0]        net_logic,
	output logic [NLOG-1:0]        fb_logic,
	output logic [15:0]            net_cmd_port,
	output logic [15:0]            net_dat_port
);
	import iot_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		iot_state_type               st;
		logic [2:0]                  trg_s;
		logic [2:0]                  enc_s;
		logic [31:0]                 div;
		logic [31:0]                 now;
		logic [31:0]                 tstamp;
		logic                        run;
		logic                        enc;
		logic                        all;
		iot_sig_type                 sig;
		logic                        npn;
		logic [31:0]                 tdly;
		logic [31:0]                 rdly;
		logic [31:0]                 rdur;
		logic [NOUT-1:0]             inv;
		logic [NOUT-1:0]             oen;
		logic [3:0]                  ifen;
		logic [NLOG-1:0]             lsel;
		logic [15:0]                 pcmd;
		logic [15:0]                 pdat;
		logic [DEPTH-1:0][31:0]      qst;
		logic [DEPTH-1:0][NOUT-1:0]  qres;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 qn;
		logic [NOUT-1:0]             lvl;
		logic [NOUT-1:0][31:0]       ost;
		logic [NLOG-1:0]             lg;
		logic                        rdy;
		logic                        valid;
		logic                        start;
		logic [NOUT-1:0]             pin;
		logic                        rdy_pin;
		logic                        val_pin;
		logic [3:0][NLOG-1:0]        ifo;
		logic [31:0]                 rdata;
	} iot_reg_type;

	iot_reg_type q;
	iot_reg_type d;

	logic        tick;
	logic        trg_rise;
	logic        push;
	logic        pop;
	logic        flush;
	logic        leave_run;
	logic [31:0] rd_mux;

	always_comb begin
		d         = q;
		tick      = 1'b0;
		trg_rise  = 1'b0;
		push      = 1'b0;
		pop       = 1'b0;
		flush     = 1'b0;
		leave_run = 1'b0;
		rd_mux    = 32'h0;
		d.start   = 1'b0;

		// pin synchronisers, third stage only for edge detection
		d.trg_s  = {q.trg_s[1:0], trig_pin};
		d.enc_s  = {q.enc_s[1:0], enc_pin};
		trg_rise = q.trg_s[1] & ~q.trg_s[2];

		// time base: ms ticks or encoder steps
		d.div = (q.div == 32'(MS_CYCLES - 1)) ? 32'h0 : 32'(q.div + 32'h1);
		if (q.enc) begin
			tick = q.enc_s[1] & ~q.enc_s[2];
		end else begin
			tick = (q.div == 32'(MS_CYCLES - 1));
		end
		d.now = 32'(q.now + {31'h0, tick});

		// register writes
		if (bus.wr) begin
			unique case (bus.addr)
				`IOT_REG_CTRL: begin
					d.run = bus.wdata[`IOT_CTRL_RUN];
					d.enc = bus.wdata[`IOT_CTRL_ENC];
					d.all = bus.wdata[`IOT_CTRL_ALL];
					d.sig = iot_sig_type'(bus.wdata[`IOT_CTRL_SIG +: 2]);
					d.npn = bus.wdata[`IOT_CTRL_NPN];
					flush = bus.wdata[`IOT_CTRL_JOB];
					leave_run = q.run & ~bus.wdata[`IOT_CTRL_RUN];
				end
				`IOT_REG_TDLY:  d.tdly = bus.wdata;
				`IOT_REG_RDLY:  d.rdly = bus.wdata;
				`IOT_REG_RDUR:  d.rdur = bus.wdata;
				`IOT_REG_INV:   d.inv  = bus.wdata[NOUT-1:0];
				`IOT_REG_OEN:   d.oen  = bus.wdata[NOUT-1:0];
				`IOT_REG_IFEN:  d.ifen = bus.wdata[3:0];
				`IOT_REG_LSEL:  d.lsel = bus.wdata[NLOG-1:0];
				`IOT_REG_PORTS: begin
					d.pcmd = bus.wdata[15:0];
					d.pdat = bus.wdata[31:16];
				end
				default: ;
			endcase
		end

		// valid duration: drop outputs whose hold time has run out
		if (q.sig == IOT_SIG_DUR) begin
			for (int i = 0; i < NOUT; i++) begin
				if (q.lvl[i] && (32'(q.now - q.ost[i]) >= q.rdur)) begin
					d.lvl[i] = 1'b0;
				end
			end
		end

		// trigger sequence
		unique case (q.st)
			IOT_IDLE: begin
				if (trg_rise && q.rdy) begin
					d.st     = IOT_TDLY;
					d.tstamp = q.now;
					d.valid  = 1'b0;
					if (q.sig == IOT_SIG_TRIG) begin
						d.lvl = '0;
						if (!q.all) begin
							d.lvl[0] = q.lvl[0];
						end
					end
				end
			end
			IOT_TDLY: begin
				if (32'(q.now - q.tstamp) >= q.tdly) begin
					d.st    = IOT_EVAL;
					d.start = 1'b1;
				end
			end
			IOT_EVAL: begin
				if (eval_done) begin
					d.st = IOT_IDLE;
					push = 1'b1;
					for (int k = 0; k < NLOG; k++) begin
						d.lg[k] = q.lsel[k] ? expr_res[k] : det_res[k];
					end
					if (!q.all) begin
						for (int i = 1; i < NOUT; i++) begin
							d.lvl[i] = eval_res[i];
							d.ost[i] = q.now;
						end
						d.valid = 1'b1;
					end
				end
			end
			default: d.st = IOT_IDLE;
		endcase

		// delayed results leave the queue oldest first
		if ((q.qn != '0) && (32'(q.now - q.qst[q.rp]) >= q.rdly)) begin
			pop = 1'b1;
			if (q.all) begin
				d.lvl   = q.qres[q.rp];
				d.valid = 1'b1;
				for (int i = 0; i < NOUT; i++) begin
					d.ost[i] = q.now;
				end
			end else begin
				d.lvl[0] = q.qres[q.rp][0];
				d.ost[0] = q.now;
			end
		end

		if (push) begin
			d.qst[q.wp]  = q.tstamp;
			d.qres[q.wp] = eval_res;
			d.wp         = AW'(q.wp + AW'(1));
		end
		if (pop) begin
			d.rp = AW'(q.rp + AW'(1));
		end
		d.qn = (AW+1)'(q.qn + (AW+1)'(push) - (AW+1)'(pop));

		// job change and leaving run mode drop pending results
		if (flush || leave_run) begin
			d.qn = '0;
			d.wp = '0;
			d.rp = '0;
		end
		if (leave_run) begin
			d.st    = IOT_IDLE;
			d.lvl   = '0;
			d.valid = 1'b0;
		end

		d.rdy = (d.st == IOT_IDLE) && d.run && (d.qn < (AW+1)'(DEPTH));

		// pin levels: invert and NPN act on default and result alike
		d.pin = (d.lvl & d.oen) ^ d.inv ^ {NOUT{d.npn}};
		d.rdy_pin = (d.rdy & d.ifen[`IOT_IF_IO]) ^ d.npn;
		d.val_pin = (d.valid & d.ifen[`IOT_IF_IO]) ^ d.npn;
		for (int j = 1; j < 4; j++) begin
			d.ifo[j] = d.lg & {NLOG{d.ifen[j]}};
		end
		d.ifo[0] = '0;

		// register reads, answered in the next cycle
		if (bus.rd) begin
			unique case (bus.addr)
				`IOT_REG_CTRL:  rd_mux = 32'({q.npn, q.sig, q.all, q.enc, q.run});
				`IOT_REG_TDLY:  rd_mux = q.tdly;
				`IOT_REG_RDLY:  rd_mux = q.rdly;
				`IOT_REG_RDUR:  rd_mux = q.rdur;
				`IOT_REG_INV:   rd_mux = 32'(q.inv);
				`IOT_REG_OEN:   rd_mux = 32'(q.oen);
				`IOT_REG_IFEN:  rd_mux = 32'(q.ifen);
				`IOT_REG_LSEL:  rd_mux = 32'(q.lsel);
				`IOT_REG_PORTS: rd_mux = {q.pdat, q.pcmd};
				`IOT_REG_STAT:  rd_mux = 32'({q.qn, q.st, q.valid, q.rdy});
				`IOT_REG_OUTS:  rd_mux = 32'({q.lg, q.lvl});
				default:        rd_mux = 32'h0;
			endcase
		end
		d.rdata = rd_mux;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q      <= '0;
			q.st   <= IOT_IDLE;
			q.sig  <= IOT_SIG_RESULT;
			q.oen  <= '1;
			q.ifen <= `IOT_IFEN_RST;
			q.pcmd <= `IOT_NET_CMD;
			q.pdat <= `IOT_NET_DAT;
		end else begin
			q <= d;
		end
	end

	assign rdata        = q.rdata;
	assign eval_start   = q.start;
	assign out_pin      = q.pin;
	assign ready_pin    = q.rdy_pin;
	assign valid_pin    = q.val_pin;
	assign ser_logic    = q.ifo[`IOT_IF_SER];
	assign net_logic    = q.ifo[`IOT_IF_NET];
	assign fb_logic     = q.ifo[`IOT_IF_FB];
	assign net_cmd_port = q.pcmd;
	assign net_dat_port = q.pdat;

endmodule : iot_timing

/* File: iot_timing_sva.sv */
// port checks for the inspection output timing block
// assumes npn off and the io interface enabled whenever triggers arrive
`timescale 1ns/1ns
module iot_timing_sva (
	// clock and reset
	input wire logic                 sys_clk,
	input wire logic                 sys_rst,
	// register port
	input wire iot_pkg::iot_bus_type bus,
	input wire logic [31:0]          rdata,
	// handshake and evaluation
	input wire logic                 trig_pin,
	input wire logic                 eval_start,
	input wire logic                 eval_done,
	input wire logic                 ready_pin,
	input wire logic                 valid_pin,
	// network ports
	input wire logic [15:0]          net_cmd_port,
	input wire logic [15:0]          net_dat_port
);
	import iot_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	AST_PORT_RESET: assert property ($past(sys_rst, 2) && $past(sys_rst) |->
		net_cmd_port == 16'h07d6 && net_dat_port == 16'h07d5) else $error("port numbers wrong after reset");
	AST_TRIG_DROP: assert property ($rose(trig_pin) && ready_pin |-> ##[3:8] !ready_pin && !valid_pin)
		else $error("trigger did not drop ready and valid");
	AST_START_BUSY: assert property (eval_start |-> !ready_pin && !valid_pin)
		else $error("evaluation started while ready or valid");
	AST_START_PULSE: assert property (eval_start |=> !eval_start)
		else $error("start pulse longer than one cycle");
	AST_DONE_READY: assert property (eval_done && !ready_pin |-> ##2 ready_pin)
		else $error("ready not back two cycles after done");
	AST_VALID_RISE: assert property ($rose(valid_pin) |-> ready_pin)
		else $error("valid rose while busy");
	AST_READY_FALL: assert property ($fell(ready_pin) |-> !valid_pin)
		else $error("ready fell with valid still high");
	AST_RD_IDLE: assert property (!$past(bus.rd) |-> rdata == 32'h0)
		else $error("read data outside the read slot");
	cover property (eval_start);
	cover property ($rose(valid_pin) && ready_pin);
	cover property ($fell(ready_pin));
endmodule : iot_timing_sva

bind iot_timing iot_timing_sva i_sva (.*);

/* File: iot_trig_src.sv */
// trigger source standing in for a plc or light barrier
// assumes ready_pin in pnp polarity
`timescale 1ns/1ns
module iot_trig_src (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// request from the bench and handshake
	input  wire logic go,
	input  wire logic ready_pin,
	output logic      trig_pin
);
	logic [2:0] hold_q = 3'h0;
	always @(posedge sys_clk) begin
		if (sys_rst)
			hold_q <= 3'h0;
		else if (hold_q != 3'h0)
			hold_q <= hold_q - 3'h1;
		else if (go && ready_pin)
			hold_q <= 3'h5;
	end
	assign trig_pin = (hold_q != 3'h0);
endmodule : iot_trig_src

/* File: iot_timing_test.sv */
// self-checking bench for the inspection output timing block
// assumes a ten-cycle tick so delays stay short
`timescale 1ns/1ns
`include "iot_cfg.svh"
module iot_timing_test;
	import iot_pkg::*;
	logic        sys_clk = 0, sys_rst = 1, enc_pin = 0, go = 0, eval_done = 0, rd_q = 0;
	logic        trig_pin, eval_start, ready_pin, valid_pin;
	iot_bus_type bus = '0;
	logic [31:0] rdata, exp_q[$];
	logic [4:0]  eval_res = '0, out_pin, r;
	logic [3:0]  det_res = '0, expr_res = '0, ser_logic, net_logic, fb_logic;
	logic [15:0] net_cmd_port, net_dat_port;
	int          n_mismatch = 0, n_compared = 0, seed = 45204, n;
	always #2 sys_clk = ~sys_clk;
	iot_timing #(.MS_CYCLES(10)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
		.trig_pin(trig_pin), .enc_pin(enc_pin), .eval_start(eval_start), .eval_done(eval_done),
		.eval_res(eval_res), .det_res(det_res), .expr_res(expr_res), .out_pin(out_pin),
		.ready_pin(ready_pin), .valid_pin(valid_pin), .ser_logic(ser_logic), .net_logic(net_logic),
		.fb_logic(fb_logic), .net_cmd_port(net_cmd_port), .net_dat_port(net_dat_port));
	iot_trig_src i_src (.sys_clk(sys_clk), .sys_rst(sys_rst), .go(go), .ready_pin(ready_pin),
		.trig_pin(trig_pin));
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task w(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : w
	// a read carries its expected data, which goes to the queue and also onto wdata
	task acc(input logic wr, input logic rd, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus <= '{wr, rd, a, d};
		if (rd)
			exp_q.push_back(d);
		@(posedge sys_clk);
		bus <= '0;
	endtask : acc
	task fire(output int t);
		go <= 1;
		@(posedge sys_clk);
		go <= 0;
		t = 0;
		while (eval_start !== 1'b1 && t < 300) begin
			w(1);
			t++;
		end
	endtask : fire
	task fin;
		r = 5'($random(seed)) | 5'h12;
		det_res <= 4'($random(seed));
		expr_res <= 4'($random(seed));
		eval_res <= r;
		eval_done <= 1;
		w(1);
		eval_done <= 0;
		w(4);
	endtask : fin
	task results;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	always @(posedge sys_clk) begin
		if (rd_q)
			chk("rdata", rdata, exp_q.pop_front());
		rd_q <= bus.rd;
	end
	initial begin
		#100000;
		n_mismatch++;
		results;
	end
	initial begin
		w(16);
		sys_rst <= 0;
		acc(0, 1, `IOT_REG_PORTS, 32'h07d507d6);
		acc(0, 1, `IOT_REG_IFEN, 32'hf);
		acc(0, 1, 8'h3c, 32'h0);
		acc(1, 0, `IOT_REG_PORTS, 32'h0bb80bb9);
		w(2);
		chk("cmd port", net_cmd_port, 16'h0bb9);
		chk("dat port", net_dat_port, 16'h0bb8);
		$display("reset test done");
		acc(1, 0, `IOT_REG_TDLY, 32'h2);
		acc(1, 0, `IOT_REG_CTRL, 32'h1);
		fire(n);
		chk("trigger delay", n inside {[10:32]}, 1'b1);
		fin;
		chk("out", out_pin, r);
		chk("logic out", ser_logic, det_res);
		chk("net logic", net_logic, det_res);
		chk("fb logic", fb_logic, det_res);
		acc(0, 1, `IOT_REG_OUTS, {det_res, r});
		$display("result test done");
		acc(1, 0, `IOT_REG_LSEL, 32'hf);
		acc(1, 0, `IOT_REG_CTRL, 32'h9);
		fire(n);
		chk("cleared", out_pin[4:1], 4'h0);
		fin;
		chk("expr out", ser_logic, expr_res);
		$display("trigger clear test done");
		acc(1, 0, `IOT_REG_TDLY, 32'h0);
		acc(1, 0, `IOT_REG_RDLY, 32'h8);
		acc(1, 0, `IOT_REG_CTRL, 32'h5);
		fire(n);
		fin;
		chk("ready early", {ready_pin, valid_pin}, 2'b10);
		n = 0;
		while (valid_pin !== 1'b1 && n < 200) begin
			w(1);
			n++;
		end
		chk("result delay", n inside {[50:90]}, 1'b1);
		chk("delayed out", out_pin, r);
		$display("delay test done");
		acc(1, 0, `IOT_REG_RDLY, 32'h0);
		acc(1, 0, `IOT_REG_RDUR, 32'h2);
		acc(1, 0, `IOT_REG_CTRL, 32'h11);
		fire(n);
		fin;
		chk("held", out_pin, r);
		w(40);
		chk("expired", out_pin, 5'h00);
		$display("duration test done");
		acc(1, 0, `IOT_REG_TDLY, 32'h2);
		acc(1, 0, `IOT_REG_CTRL, 32'h3);
		fork
			fire(n);
			begin
				w(40);
				repeat (3) begin
					enc_pin <= 1;
					w(2);
					enc_pin <= 0;
					w(2);
				end
			end
		join
		chk("encoder steps", n inside {[41:60]}, 1'b1);
		fin;
		$display("encoder test done");
		acc(1, 0, `IOT_REG_INV, 32'ha);
		acc(1, 0, `IOT_REG_CTRL, 32'h0);
		w(2);
		chk("default", out_pin, 5'h0a);
		acc(1, 0, `IOT_REG_CTRL, 32'h20);
		w(2);
		chk("npn", {out_pin, ready_pin}, 6'h2b);
		acc(1, 0, `IOT_REG_IFEN, 32'h3);
		w(2);
		chk("net off", net_logic, 4'h0);
		chk("fb off", fb_logic, 4'h0);
		$display("config test done");
		w(4);
		results;
	end
endmodule : iot_timing_test
